/* design/itu_consts.svh */
`ifndef ITU_CONSTS_SVH
`define ITU_CONSTS_SVH
// ------------------------------------------------------------
// register addresses on the sfr port
// ------------------------------------------------------------
`define ITU_ADDR_CTRL      8'ha1
`define ITU_ADDR_SUB       8'ha2
`define ITU_ADDR_SEC       8'ha3
`define ITU_ADDR_MIN       8'ha4
`define ITU_ADDR_HOUR      8'ha5
`define ITU_ADDR_CMP       8'ha6
// ------------------------------------------------------------
// reset values and control field positions
// ------------------------------------------------------------
`define ITU_CTRL_RESET     8'h00
`define ITU_CMP_RESET      8'h00
`define ITU_TIME_RESET     8'h00
`define ITU_BIT_HOUR24     6
`define ITU_BIT_TB_HI      5
`define ITU_BIT_TB_LO      4
`define ITU_BIT_ONESHOT    3
`define ITU_BIT_FLAG       2
`define ITU_BIT_CNTEN      1
`define ITU_BIT_CLKEN      0
// ------------------------------------------------------------
// timing and counter limits
// ------------------------------------------------------------
`define ITU_XTAL_HZ        32768
`define ITU_STEPS_PER_SEC  128
`define ITU_XTAL_PER_STEP  (`ITU_XTAL_HZ / `ITU_STEPS_PER_SEC)
`define ITU_SUB_LAST       8'h7f
`define ITU_SEC_LAST       8'h3b
`define ITU_MIN_LAST       8'h3b
`define ITU_HOUR_LAST_24   8'h17
`define ITU_HOUR_LAST_FULL 8'hff
`define ITU_VECTOR         16'h0053
`endif

/* design/itu_pkg.sv */
package itu_pkg;
   // sfr access sequencer, gray along idle -> wait -> done
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_WAIT = 2'b01,
      ACC_DONE = 2'b11
   } itu_acc_state_type;
   // interval timebase codes
   typedef enum logic [1:0] {
      TB_SUB  = 2'h0,
      TB_SEC  = 2'h1,
      TB_MIN  = 2'h2,
      TB_HOUR = 2'h3
   } itu_timebase_type;
endpackage : itu_pkg

/* design/itu_time_if.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// link between control and the time register chain
// ------------------------------------------------------------
interface itu_time_if;
   logic       tick;       // one 1/128 s step
   logic       run;        // timebase clock enable
   logic       hour24;     // hour wraps after 23
   logic [3:0] load;       // write pulse per time register
   logic [7:0] load_data;  // value for a load
   logic [31:0] cnt;       // sub, sec, min, hour bytes
   logic [3:0] ovf;        // rollover pulse per register
   modport chain (input tick, run, hour24, load, load_data, output cnt, ovf);
   modport ctrl  (output tick, run, hour24, load, load_data, input cnt, ovf);
endinterface : itu_time_if

/* design/itu_xtal_tick.sv */
`timescale 1ns/1ps
`include "itu_consts.svh"
// ------------------------------------------------------------
// crystal pin sampler and 1/128 s step divider
// ------------------------------------------------------------
module itu_xtal_tick (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // crystal pin
   input  wire logic xtal_in,
   // pulses on clk_sys
   output logic      edge_pulse,
   output logic      step_pulse
);
   logic [2:0] sync;       // two-stage sync plus edge history
   logic [7:0] pre;        // crystal edges within one step
   logic [7:0] next_pre;

   // rising edge of the crystal, read only from the second stage on
   assign edge_pulse = sync[1] & ~sync[2];

   // prescaler next value
   always_comb begin
      next_pre   = pre;
      step_pulse = 1'b0;
      if (edge_pulse) begin
         if (pre == 8'(`ITU_XTAL_PER_STEP - 1)) begin
            next_pre   = 8'h00;
            step_pulse = 1'b1;
         end else begin
            next_pre = pre + 8'h01;
         end
      end
   end

   // registers only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync <= 3'h0;
         pre  <= 8'h00;
      end else begin
         sync <= {sync[1:0], xtal_in};
         pre  <= next_pre;
      end
   end

   property p_step_on_edge;
      @(posedge clk_sys) disable iff (!rstn) step_pulse |-> edge_pulse && pre == 8'hff;
   endproperty
   a_step_on_edge: assert property (p_step_on_edge) else $error("step without crystal edge");
endmodule : itu_xtal_tick

/* design/itu_time_chain.sv */
`timescale 1ns/1ps
`include "itu_consts.svh"
// ------------------------------------------------------------
// cascaded time registers with software shadows
// ------------------------------------------------------------
module itu_time_chain (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // control side
   itu_time_if.chain tp
);
   logic [7:0] last [4];   // final value of each register
   logic [4:0] carry;      // carry into each stage

   assign last[0]  = `ITU_SUB_LAST;
   assign last[1]  = `ITU_SEC_LAST;
   assign last[2]  = `ITU_MIN_LAST;
   assign last[3]  = tp.hour24 ? `ITU_HOUR_LAST_24 : `ITU_HOUR_LAST_FULL;
   assign carry[0] = tp.run & tp.tick;

   for (genvar gi = 0; gi < 4; gi++) begin : g_stage
      logic [7:0] cnt_q;        // live count
      logic [7:0] shadow_q;     // last value software wrote
      logic [7:0] next_cnt;
      logic [7:0] next_shadow;
      logic       wrap;

      // >= so an out-of-range load in 24 h mode still wraps
      assign wrap = cnt_q >= last[gi];
      assign carry[gi + 1] = carry[gi] & wrap;
      assign tp.ovf[gi] = carry[gi + 1];
      assign tp.cnt[gi * 8 +: 8] = cnt_q;

      // next count: load, restore, or cascade step
      always_comb begin
         next_cnt    = cnt_q;
         next_shadow = shadow_q;
         if (tp.load[gi]) begin
            next_cnt    = tp.load_data;
            next_shadow = tp.load_data;
         end else if (!tp.run) begin
            next_cnt = shadow_q;
         end else if (carry[gi]) begin
            next_cnt = wrap ? 8'h00 : cnt_q + 8'h01;
         end
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) begin
            cnt_q    <= `ITU_TIME_RESET;
            shadow_q <= `ITU_TIME_RESET;
         end else begin
            cnt_q    <= next_cnt;
            shadow_q <= next_shadow;
         end
      end
   end

   property p_sub_wrap;
      @(posedge clk_sys) disable iff (!rstn)
         carry[0] && tp.cnt[7:0] == 8'h7f && !tp.load[0] |=> tp.cnt[7:0] == 8'h00;
   endproperty
   a_sub_wrap: assert property (p_sub_wrap) else $error("sub-second did not wrap");
endmodule : itu_time_chain

/* design/itu_interval_timer.sv */
`timescale 1ns/1ps
`include "itu_consts.svh"
// Behaviour
// - timeouts from one second (one sub-second overflow) to 65536 h
// - counting is paced by the 32.768 kHz crystal
// - counting continues through power-down
// - sfr accesses complete on a crystal edge
// - interval counter steps on selected register overflow
// - match sets flag, raises enabled interrupt
// - enabled flag wakes from power-down to vector 0053h
// - software may preload the time registers
// - control bit 7 ignored, reads zero
// - control bit 6 picks 24 h or 256 h
// - bits 5:4 pick sub, second, minute or hour timebase
// - one-shot clears count enable, else reload
// - interval counter runs only while enabled
// - clock enable low restores last written time
module itu_interval_timer
   import itu_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // crystal pin
   input  wire logic       xtal_in,
   // sfr port from the core
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_ack,
   output logic            sfr_busy,
   // core state
   input  wire logic       int_en,
   input  wire logic       pwr_down,
   // interrupt and wake
   output logic            irq,
   output logic            wake,
   output logic     [15:0] irq_vector
);
   import itu_pkg::*;

   // ------------------------------------------------------------
   // crystal pacing and time chain
   // ------------------------------------------------------------
   logic edge_pulse;   // one per crystal cycle
   logic step_pulse;   // one per 1/128 s

   itu_time_if tp ();

   itu_xtal_tick u_tick (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .xtal_in    (xtal_in),
      .edge_pulse (edge_pulse),
      .step_pulse (step_pulse)
   );

   itu_time_chain u_chain (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tp      (tp.chain)
   );

   // ------------------------------------------------------------
   // control state
   // ------------------------------------------------------------
   logic             hour24;        // day_hour_range_select
   itu_timebase_type tb_sel;        // timebase_select_high/low
   logic             one_shot;      // one_shot_select
   logic             flag;          // interval_match_flag
   logic             cnt_en;        // interval_count_enable
   logic             clk_en;        // timebase_clock_enable
   logic       [7:0] cmp;           // interval_compare_value
   logic       [7:0] ivl_cnt;       // 8-bit interval counter
   logic             next_hour24;
   itu_timebase_type next_tb_sel;
   logic             next_one_shot;
   logic             next_flag;
   logic             next_cnt_en;
   logic             next_clk_en;
   logic       [7:0] next_cmp;
   logic       [7:0] next_ivl_cnt;

   // ------------------------------------------------------------
   // access sequencer state
   // ------------------------------------------------------------
   itu_acc_state_type acc_state;    // idle, waiting for edge, done
   itu_acc_state_type next_acc_state;
   logic        [7:0] acc_addr;     // latched address
   logic        [7:0] acc_data;     // latched write data
   logic              acc_write;    // latched direction
   logic        [7:0] next_acc_addr;
   logic        [7:0] next_acc_data;
   logic              next_acc_write;
   logic        [7:0] next_rdata;
   logic              mapped;       // address belongs to this unit
   logic              fire;         // access completes this cycle
   logic              wr_ctrl;      // control write completes
   logic        [7:0] ctrl_view;    // control register read image
   logic              sel_ovf;      // selected timebase overflow
   logic              step;         // interval counter advances
   logic              hit;          // step lands on compare value

   assign mapped = sfr_addr >= `ITU_ADDR_CTRL && sfr_addr <= `ITU_ADDR_CMP;
   // accesses finish only on a crystal edge, as the real unit does
   assign fire    = acc_state == ACC_WAIT && edge_pulse;
   assign wr_ctrl = fire && acc_write && acc_addr == `ITU_ADDR_CTRL;
   assign ctrl_view = {1'b0, hour24, tb_sel, one_shot, flag, cnt_en, clk_en};

   // ------------------------------------------------------------
   // time chain hookup
   // ------------------------------------------------------------
   assign tp.tick      = step_pulse;
   assign tp.run       = clk_en;
   assign tp.hour24    = hour24;
   assign tp.load_data = acc_data;
   for (genvar gi = 0; gi < 4; gi++) begin : g_load
      // time registers sit at consecutive addresses after control
      assign tp.load[gi] = fire && acc_write && acc_addr == 8'(`ITU_ADDR_SUB + gi);
   end

   // ------------------------------------------------------------
   // interval step selection
   // ------------------------------------------------------------
   // overflow pulses are already gated by the clock enable
   assign sel_ovf = tp.ovf[tb_sel];
   assign step    = cnt_en && sel_ovf;
   assign hit     = step && (ivl_cnt + 8'h01) == cmp;

   // ------------------------------------------------------------
   // access sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      next_acc_state = acc_state;
      next_acc_addr  = acc_addr;
      next_acc_data  = acc_data;
      next_acc_write = acc_write;
      next_rdata     = sfr_rdata;
      unique case (acc_state)
         ACC_IDLE: begin
            // unmapped addresses belong to other units: ignored
            if ((sfr_wr || sfr_rd) && mapped) begin
               next_acc_state = ACC_WAIT;
               next_acc_addr  = sfr_addr;
               next_acc_data  = sfr_wdata;
               next_acc_write = sfr_wr;
            end
         end
         ACC_WAIT: begin
            if (edge_pulse) begin
               next_acc_state = ACC_DONE;
               if (!acc_write) begin
                  // read image taken on the crystal edge
                  unique case (acc_addr)
                     `ITU_ADDR_CTRL: next_rdata = ctrl_view;
                     `ITU_ADDR_SUB:  next_rdata = tp.cnt[7:0];
                     `ITU_ADDR_SEC:  next_rdata = tp.cnt[15:8];
                     `ITU_ADDR_MIN:  next_rdata = tp.cnt[23:16];
                     `ITU_ADDR_HOUR: next_rdata = tp.cnt[31:24];
                     default:        next_rdata = cmp;
                  endcase
               end
            end
         end
         ACC_DONE: begin
            next_acc_state = ACC_IDLE;
         end
         default: begin
            next_acc_state = ACC_IDLE;
         end
      endcase
   end

   // access sequencer registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         acc_state <= ACC_IDLE;
         acc_addr  <= 8'h00;
         acc_data  <= 8'h00;
         acc_write <= 1'b0;
         sfr_rdata <= 8'h00;
         sfr_ack   <= 1'b0;
         sfr_busy  <= 1'b0;
      end else begin
         acc_state <= next_acc_state;
         acc_addr  <= next_acc_addr;
         acc_data  <= next_acc_data;
         acc_write <= next_acc_write;
         sfr_rdata <= next_rdata;
         sfr_ack   <= fire;
         sfr_busy  <= next_acc_state != ACC_IDLE;
      end
   end

   // ------------------------------------------------------------
   // control and interval counter next state
   // ------------------------------------------------------------
   always_comb begin
      next_hour24   = hour24;
      next_tb_sel   = tb_sel;
      next_one_shot = one_shot;
      next_flag     = flag;
      next_cnt_en   = cnt_en;
      next_clk_en   = clk_en;
      next_cmp      = cmp;
      next_ivl_cnt  = ivl_cnt;
      // software writes first; bit 7 is dropped
      if (wr_ctrl) begin
         next_hour24   = acc_data[`ITU_BIT_HOUR24];
         next_tb_sel   = itu_timebase_type'(acc_data[`ITU_BIT_TB_HI:`ITU_BIT_TB_LO]);
         next_one_shot = acc_data[`ITU_BIT_ONESHOT];
         next_flag     = acc_data[`ITU_BIT_FLAG];
         next_cnt_en   = acc_data[`ITU_BIT_CNTEN];
         next_clk_en   = acc_data[`ITU_BIT_CLKEN];
      end
      if (fire && acc_write && acc_addr == `ITU_ADDR_CMP) begin
         next_cmp = acc_data;
      end
      // hardware events after, so a match beats a same-edge clear
      if (!cnt_en) begin
         // stopped counter restarts from zero when re-enabled
         next_ivl_cnt = 8'h00;
      end else if (hit) begin
         next_ivl_cnt = 8'h00;
         next_flag    = 1'b1;
         if (one_shot) begin
            next_cnt_en = 1'b0;
         end
      end else if (step) begin
         next_ivl_cnt = ivl_cnt + 8'h01;
      end
   end

   // control registers and outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hour24     <= 1'b0;
         tb_sel     <= TB_SUB;
         one_shot   <= 1'b0;
         flag       <= 1'b0;
         cnt_en     <= 1'b0;
         clk_en     <= 1'b0;
         cmp        <= `ITU_CMP_RESET;
         ivl_cnt    <= 8'h00;
         irq        <= 1'b0;
         wake       <= 1'b0;
         irq_vector <= `ITU_VECTOR;
      end else begin
         hour24     <= next_hour24;
         tb_sel     <= next_tb_sel;
         one_shot   <= next_one_shot;
         flag       <= next_flag;
         cnt_en     <= next_cnt_en;
         clk_en     <= next_clk_en;
         cmp        <= next_cmp;
         ivl_cnt    <= next_ivl_cnt;
         // the chain ignores pwr_down, so timing goes on asleep
         irq        <= flag && int_en;
         wake       <= flag && int_en && pwr_down;
         irq_vector <= `ITU_VECTOR;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_ack_after_edge;
      @(posedge clk_sys) disable iff (!rstn) acc_state == ACC_WAIT && edge_pulse |=> sfr_ack ##1 !sfr_busy;
   endproperty
   a_ack_after_edge: assert property (p_ack_after_edge) else $error("access not acked on edge");

   property p_match_sets_flag;
      @(posedge clk_sys) disable iff (!rstn) hit |=> flag && ivl_cnt == 8'h00;
   endproperty
   a_match_sets_flag: assert property (p_match_sets_flag) else $error("match did not set flag");

   property p_one_shot_stops;
      @(posedge clk_sys) disable iff (!rstn) hit && one_shot |=> !cnt_en;
   endproperty
   a_one_shot_stops: assert property (p_one_shot_stops) else $error("one-shot kept counting");

   property p_stopped_clear;
      @(posedge clk_sys) disable iff (!rstn) !cnt_en |=> ivl_cnt == 8'h00;
   endproperty
   a_stopped_clear: assert property (p_stopped_clear) else $error("counter moved while disabled");

   property p_irq_follows;
      @(posedge clk_sys) disable iff (!rstn) flag && int_en |=> irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

   // a clear flag or a masked request must drop the line one cycle later
   property p_irq_quiet;
      @(posedge clk_sys) disable iff (!rstn) !(flag && int_en) |=> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enabled flag");

   property p_wake;
      @(posedge clk_sys) disable iff (!rstn) flag && int_en && pwr_down |=> wake && irq_vector == 16'h0053;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake from power-down");

   property p_bit7_zero;
      @(posedge clk_sys) disable iff (!rstn) fire && !acc_write && acc_addr == `ITU_ADDR_CTRL |=> !sfr_rdata[7];
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 read back set");

   property p_flag_sticky;
      @(posedge clk_sys) disable iff (!rstn) flag && !wr_ctrl |=> flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

   property p_step_advances;
      @(posedge clk_sys) disable iff (!rstn) step && !hit |=> ivl_cnt == $past(ivl_cnt) + 8'h01;
   endproperty
   a_step_advances: assert property (p_step_advances) else $error("interval step lost");
endmodule : itu_interval_timer

/* dv/itu_core_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// core side: one sfr access at a time
// ------------------------------------------------------------
module itu_core_model (
   // clock
   input  wire logic       clk_sys,
   // request
   output logic      [7:0] sfr_addr,
   output logic      [7:0] sfr_wdata,
   output logic            sfr_wr,
   output logic            sfr_rd,
   // answer
   input  wire logic [7:0] sfr_rdata,
   input  wire logic       sfr_ack
);
   // idle bus at time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // holds the request until ack or 64 clocks; a crystal edge ends it, so waits are long
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 8'h00;
      @(posedge clk_sys);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = wr;
      sfr_rd = !wr;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge clk_sys);
         if (sfr_ack === 1'b1) begin
            ok = 1'b1;
            q = sfr_rdata;
         end
      end
      #1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      // released lines show a changed pattern, never the last value
      sfr_addr = ~a;
      sfr_wdata = ~d;
   endtask : acc
endmodule : itu_core_model

/* dv/time_interval_counter_tb_top.sv */
`timescale 1ns/1ps
module time_interval_counter_tb_top;
   import itu_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        xtal_in = 1'b0;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, q, mctrl;
   logic        sfr_wr, sfr_rd, sfr_ack, sfr_busy, ok, irq, wake;
   logic        int_en = 1'b0;
   logic        pwr_down = 1'b0;
   logic [15:0] irq_vector;
   int          mt[4], mw[4], mcnt, mcmp, k, i;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   // 100 mhz clock; crystal runs fast so a step is 1024 clocks
   always #5 clk_sys = ~clk_sys;
   always #20 xtal_in = ~xtal_in;
   itu_core_model core (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_ack(sfr_ack));
   itu_interval_timer uut (.clk_sys(clk_sys), .rstn(rstn), .xtal_in(xtal_in), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_ack(sfr_ack),
      .sfr_busy(sfr_busy), .int_en(int_en), .pwr_down(pwr_down), .irq(irq), .wake(wake),
      .irq_vector(irq_vector));
   // ------------------------------------------------------------
   // compare and model
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // last value of each time register
   function automatic int lastv(int n);
      return n == 0 ? 127 : (n < 3 ? 59 : (mctrl[6] ? 23 : 255));
   endfunction : lastv
   function automatic logic [7:0] mreg(logic [7:0] a);
      if (a == 8'ha1) return mctrl;
      if (a == 8'ha6) return 8'(mcmp);
      return 8'(mt[int'(a) - 162]);
   endfunction : mreg
   // one 1/128 s step of the cascade and the interval counter
   task automatic mstep;
      logic       c;
      logic [3:0] ov;
      c = 1'b1;
      ov = 4'h0;
      for (int n = 0; n < 4; n++) begin
         if (c) begin
            ov[n] = (mt[n] >= lastv(n));
            mt[n] = ov[n] ? 0 : mt[n] + 1;
            c = ov[n];
         end
      end
      if (!mctrl[1]) mcnt = 0;
      else if (ov[mctrl[5:4]]) begin
         mcnt = (mcnt + 1) % 256;
         if (mcnt == mcmp) begin
            mcnt = 0;
            mctrl[2] = 1'b1;
            if (mctrl[3]) mctrl[1] = 1'b0;
         end
      end
   endtask : mstep
   // write through the core model and mirror it
   task automatic wr(logic [7:0] a, logic [7:0] d);
      core.acc(1'b1, a, d, q, ok);
      chk("wr_ack", 16'h1, 16'(ok));
      chk("busy", 16'h0, 16'(sfr_busy));
      if (a == 8'ha1) begin
         if (!d[0]) mt = mw;
         if (!d[1]) mcnt = 0;
         mctrl = d & 8'h7f;
      end else if (a == 8'ha6) mcmp = d;
      else begin
         mt[int'(a) - 162] = d;
         mw[int'(a) - 162] = d;
      end
   endtask : wr
   task automatic rd_all;
      for (int a = 161; a < 167; a++) begin
         core.acc(1'b0, 8'(a), 8'h00, q, ok);
         chk($sformatf("reg_%h", a), 16'(mreg(8'(a))), 16'(q));
      end
   endtask : rd_all
   // poll the sub-second register until the design steps
   task automatic step_wait;
      logic [7:0] s0;
      s0 = 8'(mt[0]);
      q = s0;
      for (int n = 0; n < 400 && q === s0; n++) core.acc(1'b0, 8'ha2, 8'h00, q, ok);
      chk("step_seen", 16'h1, 16'(q !== s0));
      mstep;
   endtask : step_wait
   task automatic chkirq;
      repeat (3) @(posedge clk_sys);
      chk("irq", 16'(mctrl[2] & int_en), 16'(irq));
      chk("wake", 16'(mctrl[2] & int_en & pwr_down), 16'(wake));
   endtask : chkirq
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      mt = '{0, 0, 0, 0};
      mw = '{0, 0, 0, 0};
      mcnt = 0;
      mcmp = 0;
      mctrl = 8'h00;
      void'($urandom(32'h3eef));
      repeat (2) @(posedge clk_sys);
      #1 rstn = 1'b1;
      // reset values, unmapped place, unused control bit
      rd_all;
      core.acc(1'b0, 8'ha7, 8'h00, q, ok);
      chk("unmapped_ack", 16'h0, 16'(ok));
      wr(8'ha1, 8'hc0);
      rd_all;
      chk("vector", 16'h0053, irq_vector);
      $display("test 1 done");
      // each timebase code, one-shot, preload and restore
      int_en = 1'b1;
      for (k = 0; k < 4; k++) begin
         pwr_down = k[1];
         wr(8'ha1, {1'b0, k[0], 6'h00});
         for (i = 0; i < 4; i++) wr(8'(162 + i), i <= k ? 8'(lastv(i)) : 8'($urandom % 20));
         wr(8'ha6, 8'h01);
         wr(8'ha1, {1'b0, k[0], k[1:0], 4'hb});
         step_wait;
         rd_all;
         chkirq;
         wr(8'ha1, mctrl & 8'hfe);
         rd_all;
      end
      $display("test 2 done");
      // periodic mode two overflows short of a reload, flag stays clear, counting enabled
      wr(8'ha1, 8'h00);
      wr(8'ha6, 8'h03);
      wr(8'ha1, 8'h03);
      repeat (5) begin
         step_wait;
         rd_all;
         chkirq;
      end
      wr(8'ha1, mctrl & 8'hfb);
      chkirq;
      // one sub-second overflow so far leaves the count at one, two overflows short of the compare value
      step_wait;
      rd_all;
      chkirq;
      wr(8'ha1, 8'h01);
      repeat (4) step_wait;
      rd_all;
      $display("test 3 done");
      end_sim;
   end
   // watchdog: the tests take about 14400 clocks, 14 steps of 1024
   initial begin
      #400000;
      n_mismatch++;
      end_sim;
   end
endmodule : time_interval_counter_tb_top
